// ### converter_pkg.sv
package converter_pkg;

	// ------------------------------------------------------------
	// Register addresses and reset values on the special-function-register bus.
	// ------------------------------------------------------------
	localparam logic [7:0] INPUT_CONTROL_ADDR = 8'hda;
	localparam logic [7:0] RESULT_HIGH_ADDR   = 8'hdd;
	localparam logic [7:0] INPUT_CONTROL_RST  = 8'h00;
	localparam logic [7:0] RESULT_HIGH_RST    = 8'h00;

	// ------------------------------------------------------------
	// Field positions of the input control register.
	// ------------------------------------------------------------
	localparam int CONNECT_BIT   = 7;
	localparam int REF_BIT       = 6;
	localparam int TRIG_HI_BIT   = 5;
	localparam int TRIG_LO_BIT   = 4;
	localparam int DIFFERENTIAL_ENABLE_BIT      = 3;
	localparam int CHAN_HI_BIT   = 2;
	localparam int CHAN_LO_BIT   = 0;

	// ------------------------------------------------------------
	// Trigger sources and converter geometry.
	// ------------------------------------------------------------
	localparam logic [1:0] TRIG_SOFTWARE = 2'h0;
	localparam logic [1:0] TRIG_TIMER0   = 2'h1;
	localparam logic [1:0] TRIG_TIMER1   = 2'h2;
	localparam logic [1:0] TRIG_TIMER2   = 2'h3;
	localparam int         SAMPLE_BITS   = 10;
	localparam logic [4:0] CONVERT_CYCLES = 5'h10;

	typedef enum logic [1:0] {REF_SUPPLY, REF_INTERNAL} reference_t;

endpackage

// ### converter_conv_if.sv
interface converter_conv_if;
	logic       start;
	logic       done;
	logic [9:0] sample;
	logic [9:0] captured;

	modport control
	(
		output start,
		input  done,
		input  captured
	);
	modport engine
	(
		input  start,
		output done,
		input  sample,
		output captured
	);
endinterface

// ### converter_engine.sv
module converter_engine
(
	input  wire logic          clk_in,
	input  wire logic          rst_n_in,
	converter_conv_if.engine   conv
);

	logic [4:0] count_r;
	logic       busy_r;
	logic       done_r;
	logic [9:0] captured_r;

	// ------------------------------------------------------------
	// Conversion timing and sample capture.
	// ------------------------------------------------------------
	always_ff @(posedge clk_in or negedge rst_n_in)
	begin
		if (!rst_n_in)
		begin
			count_r    <= 5'h00;
			busy_r     <= 1'b0;
			done_r     <= 1'b0;
			captured_r <= 10'h000;
		end
		else
		begin
			done_r <= 1'b0;
			if (busy_r)
			begin
				if (count_r == 5'h01)
				begin
					busy_r     <= 1'b0;
					done_r     <= 1'b1;
					captured_r <= conv.sample;
				end
				count_r <= count_r - 5'h01;
			end
			else if (conv.start)
			begin
				busy_r  <= 1'b1;
				count_r <= converter_pkg::CONVERT_CYCLES;
			end
		end
	end

	assign conv.done     = done_r;
	assign conv.captured = captured_r;

endmodule // converter_engine

// ### converter_input_and_result_regs.sv
module converter_input_and_result_regs
(
	input  wire logic       clk_in,
	input  wire logic       rst_n_in,
	input  wire logic [7:0] sfr_addr_in,
	input  wire logic       sfr_wr_in,
	input  wire logic       sfr_rd_in,
	input  wire logic [7:0] sfr_wdata_in,
	output logic      [7:0] sfr_rdata_out,
	input  wire logic       start_write_in,
	input  wire logic       left_adjust_in,
	input  wire logic       timer0_overflow_in,
	input  wire logic       timer1_overflow_in,
	input  wire logic       timer2_overflow_in,
	input  wire logic       irq_service_in,
	input  wire logic [9:0] sample_in,
	output logic            start_busy_out,
	output logic            conversion_complete_flag_out,
	output logic      [7:0] positive_select_out,
	output logic            negative_half_supply_out,
	output logic            reference_internal_out,
	output logic            differential_out,
	output logic      [7:0] result_low_out
);

	converter_conv_if conv ();

	logic [7:0]  control_r;
	logic [7:0]  result_high_r;
	logic [7:0]  result_low_r;
	logic        busy_r;
	logic        flag_r;
	logic        start_pulse;
	logic        hw_trigger;
	logic [15:0] justified;
	logic [7:0]  rdata_nxt;
	logic [7:0]  pos_nxt;
	logic        neg_nxt;

	function automatic logic [15:0] justify(input logic [9:0] s,
		input logic left);
		if (left)
			justify = {s, 6'h00};
		else
			justify = {{6{s[9]}}, s};
	endfunction

	function automatic logic [1:0] trigger_field(input logic [7:0] c);
		trigger_field =
			c[converter_pkg::TRIG_HI_BIT:converter_pkg::TRIG_LO_BIT];
	endfunction

	assign conv.sample = sample_in;

	converter_engine engine_u
	(
		.clk_in   (clk_in),
		.rst_n_in (rst_n_in),
		.conv     (conv)
	);

	// ------------------------------------------------------------
	// Input control register.
	// ------------------------------------------------------------
	always_ff @(posedge clk_in or negedge rst_n_in)
	begin
		if (!rst_n_in)
			control_r <= converter_pkg::INPUT_CONTROL_RST;
		else if (sfr_wr_in
			&& sfr_addr_in == converter_pkg::INPUT_CONTROL_ADDR)
			control_r <= sfr_wdata_in;
	end

	// ------------------------------------------------------------
	// Trigger selection.
	// ------------------------------------------------------------
	always_comb
	begin
		case (trigger_field(control_r))
			converter_pkg::TRIG_TIMER0: hw_trigger = timer0_overflow_in;
			converter_pkg::TRIG_TIMER1: hw_trigger = timer1_overflow_in;
			converter_pkg::TRIG_TIMER2: hw_trigger = timer2_overflow_in;
			default:                    hw_trigger = 1'b0;
		endcase
	end

	assign start_pulse = !busy_r
		&& ((trigger_field(control_r) == converter_pkg::TRIG_SOFTWARE)
		? start_write_in : hw_trigger);
	assign conv.start = start_pulse;

	// ------------------------------------------------------------
	// Busy, complete flag and result capture.
	// ------------------------------------------------------------
	always_ff @(posedge clk_in or negedge rst_n_in)
	begin
		if (!rst_n_in)
			busy_r <= 1'b0;
		else if (start_pulse)
			busy_r <= 1'b1;
		else if (conv.done)
			busy_r <= 1'b0;
	end

	always_ff @(posedge clk_in or negedge rst_n_in)
	begin
		if (!rst_n_in)
			flag_r <= 1'b0;
		else if (conv.done)
			flag_r <= 1'b1;
		else if (irq_service_in)
			flag_r <= 1'b0;
	end

	assign justified = justify(conv.captured, left_adjust_in);

	always_ff @(posedge clk_in or negedge rst_n_in)
	begin
		if (!rst_n_in)
		begin
			result_high_r <= converter_pkg::RESULT_HIGH_RST;
			result_low_r  <= 8'h00;
		end
		else if (conv.done)
		begin
			result_high_r <= justified[15:8];
			result_low_r  <= justified[7:0];
		end
	end

	// ------------------------------------------------------------
	// Register read port.
	// ------------------------------------------------------------
	always_comb
	begin
		if (sfr_addr_in == converter_pkg::INPUT_CONTROL_ADDR)
			rdata_nxt = control_r;
		else if (sfr_addr_in == converter_pkg::RESULT_HIGH_ADDR)
			rdata_nxt = result_high_r;
		else
			rdata_nxt = 8'h00;
	end

	always_ff @(posedge clk_in or negedge rst_n_in)
	begin
		if (!rst_n_in)
			sfr_rdata_out <= 8'h00;
		else if (sfr_rd_in)
			sfr_rdata_out <= rdata_nxt;
	end

	// ------------------------------------------------------------
	// Analog routing controls.
	// ------------------------------------------------------------
	always_comb
	begin
		pos_nxt = 8'h00;
		neg_nxt = 1'b0;
		if (control_r[converter_pkg::CONNECT_BIT])
		begin
			neg_nxt = !control_r[converter_pkg::DIFFERENTIAL_ENABLE_BIT];
			if (control_r[converter_pkg::DIFFERENTIAL_ENABLE_BIT])
				pos_nxt[{control_r[1:0], 1'b0}] = 1'b1;
			else
				pos_nxt[control_r[converter_pkg::CHAN_HI_BIT:
					converter_pkg::CHAN_LO_BIT]] = 1'b1;
		end
	end

	always_ff @(posedge clk_in or negedge rst_n_in)
	begin
		if (!rst_n_in)
		begin
			positive_select_out      <= 8'h00;
			negative_half_supply_out <= 1'b0;
			reference_internal_out   <= 1'b0;
			differential_out         <= 1'b0;
		end
		else
		begin
			positive_select_out      <= pos_nxt;
			negative_half_supply_out <= neg_nxt;
			reference_internal_out   <=
				control_r[converter_pkg::REF_BIT];
			differential_out         <=
				control_r[converter_pkg::DIFFERENTIAL_ENABLE_BIT];
		end
	end

	// ------------------------------------------------------------
	// Status outputs.
	// ------------------------------------------------------------
	always_ff @(posedge clk_in or negedge rst_n_in)
	begin
		if (!rst_n_in)
		begin
			start_busy_out               <= 1'b0;
			conversion_complete_flag_out <= 1'b0;
		end
		else
		begin
			start_busy_out               <= busy_r || start_pulse;
			conversion_complete_flag_out <= conv.done
				|| (flag_r && !irq_service_in);
		end
	end

	// ------------------------------------------------------------
	// Low result byte output.
	// ------------------------------------------------------------
	always_ff @(posedge clk_in or negedge rst_n_in)
	begin
		if (!rst_n_in)
			result_low_out <= 8'h00;
		else
			result_low_out <= result_low_r;
	end

endmodule // converter_input_and_result_regs

// ### converter_monitor.sv
module converter_monitor
(
	input wire logic       clk_in,
	input wire logic       rst_n_in,
	input wire logic [7:0] sfr_addr_in,
	input wire logic       sfr_wr_in,
	input wire logic       sfr_rd_in,
	input wire logic [7:0] sfr_wdata_in,
	input wire logic [7:0] sfr_rdata_out,
	input wire logic       start_write_in,
	input wire logic       timer0_overflow_in,
	input wire logic       irq_service_in,
	input wire logic       start_busy_out,
	input wire logic       conversion_complete_flag_out,
	input wire logic       reference_internal_out,
	input wire logic       differential_out
);
	timeunit 1ns;
	timeprecision 1ns;
	logic [7:0] ctl_r;
	default clocking @(posedge clk_in); endclocking
	default disable iff (!rst_n_in);
	always_ff @(posedge clk_in or negedge rst_n_in)
		if (!rst_n_in)
			ctl_r <= 8'h00;
		else if (sfr_wr_in && sfr_addr_in == 8'hda)
			ctl_r <= sfr_wdata_in;
	a_rd_unmapped: assert property (sfr_rd_in && sfr_addr_in != 8'hda &&
		sfr_addr_in != 8'hdd |=> sfr_rdata_out == 8'h00) else $error("bad read");
	a_ref_select: assert property ($changed(ctl_r) |->
		##[0:1] reference_internal_out == ctl_r[6]) else $error("bad ref");
	a_differential_enable_select: assert property ($changed(ctl_r) |->
		##[0:1] differential_out == ctl_r[3]) else $error("bad differential_enable");
	a_soft_start: assert property (start_write_in && !start_busy_out &&
		ctl_r[5:4] == 2'h0 |=> start_busy_out) else $error("no start");
	a_timer_start: assert property (timer0_overflow_in && !start_busy_out &&
		ctl_r[5:4] == 2'h1 |=> start_busy_out) else $error("no start");
	a_busy_hold: assert property ($rose(start_busy_out) |->
		start_busy_out [*8] ##1 start_busy_out [*8] ##1 start_busy_out
		##1 start_busy_out ##1 !start_busy_out) else $error("bad busy");
	a_flag_set: assert property ($fell(start_busy_out) |->
		conversion_complete_flag_out) else $error("no flag");
	a_flag_clear: assert property (irq_service_in && !start_busy_out |=>
		!conversion_complete_flag_out) else $error("flag kept");
endmodule // converter_monitor

bind converter_input_and_result_regs converter_monitor mon (.clk_in, .rst_n_in,
	.sfr_addr_in, .sfr_wr_in, .sfr_rd_in, .sfr_wdata_in, .sfr_rdata_out,
	.start_write_in, .timer0_overflow_in, .irq_service_in, .start_busy_out,
	.conversion_complete_flag_out, .reference_internal_out, .differential_out);

// ### converter_partner.sv
module converter_partner
(
	input  wire logic       clk_in,
	input  wire logic       busy_in,
	output logic      [9:0] sample_out
);
	timeunit 1ns;
	timeprecision 1ns;
	// The analog sample holds during a conversion and moves every idle cycle.
	initial sample_out = 10'h155;
	always @(posedge clk_in)
		if (!busy_in)
			sample_out <= {sample_out[8:0], ~sample_out[9]};
endmodule // converter_partner

// ### tb.sv
module tb;
	timeunit 1ns;
	timeprecision 1ns;
	logic clk_in = 1'b0, rst_n_in = 1'b0, sfr_wr_in = 1'b0, sfr_rd_in = 1'b0;
	logic [7:0] sfr_addr_in = 8'h00, sfr_wdata_in = 8'h00, sfr_rdata_out;
	logic [7:0] positive_select_out, result_low_out;
	logic [3:0] src = 4'h0;
	logic [9:0] sample_in, smp;
	logic left_adjust = 1'b0, irq = 1'b0, start_busy_out, flag, neg, reference_select, dif;
	logic [15:0] rnd = 16'h0253, r;
	logic [7:0] ctl;
	logic [15:0] exp_q[$];
	int n_mismatch = 0, cmp_count = 0, k, i;
	always #5 clk_in = ~clk_in;
	converter_input_and_result_regs uut (.clk_in, .rst_n_in, .sfr_addr_in,
		.sfr_wr_in, .sfr_rd_in, .sfr_wdata_in, .sfr_rdata_out,
		.start_write_in(src[0]), .left_adjust_in(left_adjust),
		.timer0_overflow_in(src[1]), .timer1_overflow_in(src[2]),
		.timer2_overflow_in(src[3]), .irq_service_in(irq), .sample_in,
		.start_busy_out, .conversion_complete_flag_out(flag),
		.positive_select_out, .negative_half_supply_out(neg),
		.reference_internal_out(reference_select), .differential_out(dif), .result_low_out);
	converter_partner afe (.clk_in, .busy_in(start_busy_out),
		.sample_out(sample_in));
	function automatic logic [15:0] lfsr(input logic [15:0] v);
		return {v[14:0], v[15] ^ v[13] ^ v[12] ^ v[10]};
	endfunction
	task automatic tick;
		@(posedge clk_in);
		#1;
	endtask
	task automatic chk(input logic [15:0] got, input logic [15:0] exp);
		cmp_count++;
		if (got !== exp)
		begin
			n_mismatch++;
			$display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask
	task automatic tally_and_finish;
		if (n_mismatch == 0 && cmp_count > 0)
			$display("bench passed");
		else
			$display("bench failed");
		$finish;
	endtask
	task automatic wr(input logic [7:0] a, input logic [7:0] d);
		sfr_addr_in = a;
		sfr_wdata_in = d;
		sfr_wr_in = 1'b1;
		tick;
		sfr_wr_in = 1'b0;
		tick;
	endtask
	task automatic rdc(input logic [7:0] a, input logic [7:0] e);
		sfr_addr_in = a;
		sfr_rd_in = 1'b1;
		tick;
		sfr_rd_in = 1'b0;
		chk({8'h00, sfr_rdata_out}, {8'h00, e});
		tick;
	endtask
	initial
	begin
		repeat (10) tick;
		rst_n_in = 1'b1;
		rdc(8'hda, 8'h00);
		rdc(8'hdd, 8'h00);
		rnd = lfsr(rnd);
		wr(8'hda, rnd[7:0] & 8'h7f);
		rdc(8'hda, rnd[7:0] & 8'h7f);
		chk({8'h00, positive_select_out}, 16'h0000);
		wr(8'hdd, 8'ha5);
		rdc(8'hdd, 8'h00);
		rdc(8'h5a, 8'h00);
		for (k = 0; k < 4; k++)
		begin
			rnd = lfsr(rnd);
			ctl = {1'b0, rnd[6], 3'h0, k[2:0]};
			wr(8'hda, ctl);
			wr(8'hda, ctl | 8'h80);
			chk({8'h00, positive_select_out}, 16'h0001 << k);
			chk({neg, reference_select, dif}, {1'b1, ctl[6], 1'b0});
			wr(8'hda, ctl | 8'h88);
			chk({neg, dif}, 2'h1);
			wr(8'hda, ctl | 8'h08);
			chk({7'h00, neg, positive_select_out}, 16'h0000);
		end
		for (k = 0; k < 4; k++)
		begin
			left_adjust = k[0];
			wr(8'hda, {2'h0, k[1:0], 4'h0});
			src[(k + 1) % 4] = 1'b1;
			tick;
			src = 4'h0;
			chk(start_busy_out, 1'b0);
			tick;
			src[k] = 1'b1;
			tick;
			src[k] = 1'b0;
			chk(start_busy_out, 1'b1);
			smp = sample_in;
			exp_q.push_back(left_adjust ? {smp, 6'h00} : {{6{smp[9]}}, smp});
			for (i = 0; i < 40 && start_busy_out; i++) tick;
			if (start_busy_out !== 1'b0)
			begin
				n_mismatch++;
				tally_and_finish;
			end
			chk(flag, 1'b1);
			r = exp_q.pop_front();
			rdc(8'hdd, r[15:8]);
			chk({8'h00, result_low_out}, {8'h00, r[7:0]});
			irq = 1'b1;
			tick;
			irq = 1'b0;
			chk(flag, 1'b0);
		end
		tally_and_finish;
	end
endmodule // tb
